//--- common/csft_defines.vh
// constants for the counter status, input filter and interval timer block
// assumes a 50 MHz reference clock and a 32-bit classic wishbone slave port
`ifndef CSFT_DEFINES_VH
`define CSFT_DEFINES_VH

// clock and time base
`define CSFT_CLK_NS        20
`define CSFT_FLT_STEP_NS   100
`define CSFT_FLT_STEP_CYC  (`CSFT_FLT_STEP_NS / `CSFT_CLK_NS)
`define CSFT_MS_NS         1000000
`define CSFT_MS_CYC        (`CSFT_MS_NS / `CSFT_CLK_NS)

// widths
`define CSFT_NCH           4
`define CSFT_FLT_W         15
`define CSFT_FCNT_W        18
`define CSFT_TMR_W         13
`define CSFT_MS_W          16

// register byte offsets
`define CSFT_REG_FILT_BASE 8'h00
`define CSFT_REG_STAT_BASE 8'h10
`define CSFT_REG_EV_STS    8'h20
`define CSFT_REG_EV_CLR    8'h24
`define CSFT_REG_EV_EN     8'h28
`define CSFT_REG_TMR_IVL   8'h2C
`define CSFT_REG_TMR_STS   8'h30
`define CSFT_REG_TMR_CLR   8'h34
`define CSFT_REG_TMR_EN    8'h38
`define CSFT_GRP_MASK      8'hF0

// per-channel status word fields
`define CSFT_ST_A          0
`define CSFT_ST_B          1
`define CSFT_ST_Z          2
`define CSFT_ST_DIR        3
`define CSFT_ST_CTL        4
`define CSFT_ST_EV_LSB     8

// event bit positions inside one channel byte of the event registers
`define CSFT_EV_ABN        0
`define CSFT_EV_FLT        1
`define CSFT_EV_CARRY      2
`define CSFT_EV_BORROW     3
`define CSFT_EV_M0         4
`define CSFT_EV_M1         5
`define CSFT_EV_MUP        6
`define CSFT_EV_MDN        7

// reset values
`define CSFT_FLT_RST       15'h0000
`define CSFT_TMR_RST       13'h0000
`define CSFT_EV_RST        32'h0000_0000

`endif

//--- rtl/csft_top.v
// counter status, input noise filter and interval timer for four counter channels
// assumes inputs synchronous to ref_clk_i, a counter core that supplies carry,
// borrow and match pulses plus direction, and a classic wishbone master
//
// What this block does
// [RULE1] status shows phase a, b, z and direction
// [RULE2] status shows control input level
// [RULE3] simultaneous a/b change latches abnormal error
// [RULE4] too-short a/b pulse latches filter error
// [RULE5] wrap up from all-ones sets carry
// [RULE6] wrap down from zero sets borrow
// [RULE7] four readable count-match flags per channel
// [RULE8] all pulse and control inputs filtered
// [RULE9] new level passes after full filter time
// [RULE10] filter time off or 0.1us to 1.6384ms
// [RULE11] enabled filter delays by at least time
// [RULE12] filter disabled after reset, no delay
// [RULE13] changes shorter than filter time ignored
// [RULE14] periodic timer interrupt, 1 to 6553 ms
// [RULE15] error sampling at half filter time period
// [RULE16] unfiltered: a and b change same cycle
// [RULE17] errors raise interrupt and one-shot trigger
// [RULE18] flags sticky, cleared one by one
// [RULE19] channels fully independent of each other
`timescale 1ns/1ps
`include "csft_defines.vh"

// one input conditioner: debounce plus short-pulse detection
module csft_filt (
  input  wire                    ref_clk_i,
  input  wire                    rst_i,
  input  wire                    ce_i,
  input  wire                    raw_i,
  input  wire                    en_i,
  input  wire                    tick_i,
  input  wire [`CSFT_FCNT_W-1:0] lim_i,
  output wire                    lvl_o,
  output wire                    chg_o,
  output wire                    err_o
);
  reg                    lvl_ff;   // level handed to the counter logic
  reg [`CSFT_FCNT_W-1:0] cnt_ff;   // cycles the raw input has differed
  reg                    smp1_ff;  // last sample at source-clock tick
  reg                    smp2_ff;  // sample before that
  reg                    err_ff;   // registered error pulse
  reg                    nxt_lvl;
  reg [`CSFT_FCNT_W-1:0] nxt_cnt;
  wire                   nxt_err;

  // next level and stability counter
  always @* begin
    nxt_lvl = lvl_ff;
    nxt_cnt = {`CSFT_FCNT_W{1'b0}};
    if (!en_i) begin
      // [RULE12] bypass path
      nxt_lvl = raw_i;
    end else if (raw_i != lvl_ff) begin
      // [RULE9] [RULE11] [RULE13] hold full time
      if (cnt_ff + 1'b1 >= lim_i) begin
        nxt_lvl = raw_i;
      end else begin
        nxt_cnt = cnt_ff + 1'b1;
      end
    end
  end

  // [RULE15] level seen only once
  assign nxt_err = en_i & tick_i & (raw_i != smp1_ff) & (smp1_ff != smp2_ff);

  // state update, frozen while ce_i is low
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lvl_ff  <= 1'b0;
      cnt_ff  <= {`CSFT_FCNT_W{1'b0}};
      smp1_ff <= 1'b0;
      smp2_ff <= 1'b0;
      err_ff  <= 1'b0;
    end else if (ce_i) begin
      lvl_ff <= nxt_lvl;
      cnt_ff <= nxt_cnt;
      err_ff <= nxt_err;
      if (tick_i) begin
        smp1_ff <= raw_i;
        smp2_ff <= smp1_ff;
      end
    end
  end

  assign lvl_o = lvl_ff;
  // change is seen one cycle ahead so abnormal detection lines up with the level
  assign chg_o = nxt_lvl ^ lvl_ff;
  assign err_o = err_ff;
endmodule

module csft_top #(
  parameter MS_CYC = `CSFT_MS_CYC  // cycles per millisecond, shorten in simulation
) (
  input  wire                  ref_clk_i,
  input  wire                  rst_i,
  input  wire                  ce_i,
  input  wire                  wb_cyc_i,
  input  wire                  wb_stb_i,
  input  wire                  wb_we_i,
  input  wire [7:0]            wb_adr_i,
  input  wire [3:0]            wb_sel_i,
  input  wire [31:0]           wb_dat_i,
  output reg  [31:0]           wb_dat_o,
  output reg                   wb_ack_o,
  input  wire [`CSFT_NCH-1:0]  pha_i,
  input  wire [`CSFT_NCH-1:0]  phb_i,
  input  wire [`CSFT_NCH-1:0]  phz_i,
  input  wire [`CSFT_NCH-1:0]  ctl_i,
  input  wire [`CSFT_NCH-1:0]  dir_i,
  input  wire [`CSFT_NCH-1:0]  carry_i,
  input  wire [`CSFT_NCH-1:0]  borrow_i,
  input  wire [`CSFT_NCH-1:0]  match0_i,
  input  wire [`CSFT_NCH-1:0]  match1_i,
  input  wire [`CSFT_NCH-1:0]  match_up_i,
  input  wire [`CSFT_NCH-1:0]  match_dn_i,
  output wire [`CSFT_NCH-1:0]  pha_f_o,
  output wire [`CSFT_NCH-1:0]  phb_f_o,
  output wire [`CSFT_NCH-1:0]  phz_f_o,
  output wire [`CSFT_NCH-1:0]  ctl_f_o,
  output reg  [`CSFT_NCH-1:0]  err_shot_o,
  output reg                   irq_o
);
  localparam [31:0]           MS_LAST_W = MS_CYC - 1;                  // full-width last count
  localparam [`CSFT_MS_W-1:0] MS_LAST   = MS_LAST_W[`CSFT_MS_W-1:0];  // last prescaler count

  reg  [`CSFT_FLT_W-1:0] flt_ff [0:`CSFT_NCH-1];  // filter time in 0.1us steps, 0 = off
  reg  [31:0]            ev_sts_ff;               // sticky event flags, 8 per channel
  reg  [31:0]            ev_en_ff;                // event interrupt enables
  reg  [`CSFT_TMR_W-1:0] tmr_ivl_ff;              // timer interval in ms, 0 = stopped
  reg  [`CSFT_MS_W-1:0]  ms_cnt_ff;               // millisecond prescaler
  reg  [`CSFT_TMR_W-1:0] ivl_cnt_ff;              // elapsed ms in interval
  reg                    tmr_sts_ff;              // sticky timer flag
  reg                    tmr_en_ff;               // timer interrupt enable
  wire [31:0]            ev_w;                    // one-cycle event pulses
  wire [31:0]            bmask;                   // byte-lane write mask
  wire                   req;                     // new bus request this cycle
  wire                   wr;                      // write strobe
  wire [7:0]             adr;                     // word-aligned address
  wire [1:0]             cidx;                    // channel index from address
  wire                   ms_tick;                 // one pulse per millisecond
  wire                   tmr_fire;                // interval elapsed
  reg  [31:0]            nxt_rdat;
  reg  [`CSFT_NCH-1:0]   nxt_shot;
  integer                i;
  integer                j;                       // loop index of the shot logic only

  assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr    = req & wb_we_i;
  assign adr   = {wb_adr_i[7:2], 2'b00};
  assign cidx  = wb_adr_i[3:2];
  assign bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // per-channel filters, tick generator and abnormal detection
  genvar ch;
  generate
    for (ch = 0; ch < `CSFT_NCH; ch = ch + 1) begin : g_ch
      wire                    en;
      wire [31:0]             lim_x;      // full-width product before the cut
      wire [`CSFT_FCNT_W-1:0] lim;
      wire [`CSFT_FCNT_W-1:0] half;
      wire                    tick;
      wire                    a_chg;
      wire                    b_chg;
      wire                    a_err;
      wire                    b_err;
      wire                    abn;
      reg  [`CSFT_FCNT_W-1:0] tk_ff;      // source-clock divider
      reg                     a_seen_ff;  // a changed in this source period
      reg                     b_seen_ff;  // b changed in this source period

      // [RULE10] [RULE19] own time per channel
      assign en   = (flt_ff[ch] != `CSFT_FLT_RST);
      assign lim_x = {{(`CSFT_FCNT_W-`CSFT_FLT_W){1'b0}}, flt_ff[ch]} * `CSFT_FLT_STEP_CYC;
      assign lim  = lim_x[`CSFT_FCNT_W-1:0];
      // [RULE15] source period is half the time, rounded up
      assign half = (lim + 1'b1) >> 1;
      assign tick = ~en | (tk_ff + 1'b1 >= half);

      // source-clock divider
      always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
          tk_ff <= {`CSFT_FCNT_W{1'b0}};
        end else if (ce_i) begin
          tk_ff <= tick ? {`CSFT_FCNT_W{1'b0}} : tk_ff + 1'b1;
        end
      end

      // [RULE8] every phase and control input through a filter
      csft_filt u_a (
        .ref_clk_i (ref_clk_i), .rst_i (rst_i), .ce_i (ce_i), .raw_i (pha_i[ch]),
        .en_i (en), .tick_i (tick), .lim_i (lim),
        .lvl_o (pha_f_o[ch]), .chg_o (a_chg), .err_o (a_err)
      );
      csft_filt u_b (
        .ref_clk_i (ref_clk_i), .rst_i (rst_i), .ce_i (ce_i), .raw_i (phb_i[ch]),
        .en_i (en), .tick_i (tick), .lim_i (lim),
        .lvl_o (phb_f_o[ch]), .chg_o (b_chg), .err_o (b_err)
      );
      csft_filt u_z (
        .ref_clk_i (ref_clk_i), .rst_i (rst_i), .ce_i (ce_i), .raw_i (phz_i[ch]),
        .en_i (en), .tick_i (tick), .lim_i (lim),
        .lvl_o (phz_f_o[ch]), .chg_o (), .err_o ()
      );
      csft_filt u_c (
        .ref_clk_i (ref_clk_i), .rst_i (rst_i), .ce_i (ce_i), .raw_i (ctl_i[ch]),
        .en_i (en), .tick_i (tick), .lim_i (lim),
        .lvl_o (ctl_f_o[ch]), .chg_o (), .err_o ()
      );

      // [RULE3] [RULE16] both phases in one period
      assign abn = en ? ((a_chg | a_seen_ff) & (b_chg | b_seen_ff)) : (a_chg & b_chg);

      // change memory, emptied at each source tick or on a hit
      always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
          a_seen_ff <= 1'b0;
          b_seen_ff <= 1'b0;
        end else if (ce_i) begin
          a_seen_ff <= (tick | abn) ? 1'b0 : (a_seen_ff | a_chg);
          b_seen_ff <= (tick | abn) ? 1'b0 : (b_seen_ff | b_chg);
        end
      end

      // [RULE4] [RULE5] [RULE6] [RULE7] event byte
      assign ev_w[ch*8 +: 8] = {match_dn_i[ch], match_up_i[ch], match1_i[ch], match0_i[ch],
                                borrow_i[ch], carry_i[ch], a_err | b_err, abn};
    end
  endgenerate

  // millisecond prescaler and interval counter
  assign ms_tick  = (tmr_ivl_ff != `CSFT_TMR_RST) && (ms_cnt_ff == MS_LAST);
  assign tmr_fire = ms_tick && (ivl_cnt_ff + 1'b1 >= tmr_ivl_ff);

  // [RULE14] periodic timer
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ms_cnt_ff  <= {`CSFT_MS_W{1'b0}};
      ivl_cnt_ff <= {`CSFT_TMR_W{1'b0}};
    end else if (ce_i) begin
      if (tmr_ivl_ff == `CSFT_TMR_RST) begin
        // stopped timer restarts a full interval when programmed
        ms_cnt_ff  <= {`CSFT_MS_W{1'b0}};
        ivl_cnt_ff <= {`CSFT_TMR_W{1'b0}};
      end else if (ms_tick) begin
        ms_cnt_ff  <= {`CSFT_MS_W{1'b0}};
        ivl_cnt_ff <= tmr_fire ? {`CSFT_TMR_W{1'b0}} : ivl_cnt_ff + 1'b1;
      end else begin
        ms_cnt_ff <= ms_cnt_ff + 1'b1;
      end
    end
  end

  // read data mux, unmapped words read as zero
  always @* begin
    nxt_rdat = 32'h0000_0000;
    if ((adr & `CSFT_GRP_MASK) == `CSFT_REG_FILT_BASE) begin
      nxt_rdat[`CSFT_FLT_W-1:0] = flt_ff[cidx];
    end else if ((adr & `CSFT_GRP_MASK) == `CSFT_REG_STAT_BASE) begin
      // [RULE1] [RULE2] live levels and direction
      nxt_rdat[`CSFT_ST_A]   = pha_f_o[cidx];
      nxt_rdat[`CSFT_ST_B]   = phb_f_o[cidx];
      nxt_rdat[`CSFT_ST_Z]   = phz_f_o[cidx];
      nxt_rdat[`CSFT_ST_DIR] = dir_i[cidx];
      nxt_rdat[`CSFT_ST_CTL] = ctl_f_o[cidx];
      // [RULE7] latched flags of this channel
      nxt_rdat[`CSFT_ST_EV_LSB +: 8] = ev_sts_ff[cidx*8 +: 8];
    end else begin
      case (adr)
        `CSFT_REG_EV_STS: begin
          nxt_rdat = ev_sts_ff;
        end
        `CSFT_REG_EV_EN: begin
          nxt_rdat = ev_en_ff;
        end
        `CSFT_REG_TMR_IVL: begin
          nxt_rdat[`CSFT_TMR_W-1:0] = tmr_ivl_ff;
        end
        `CSFT_REG_TMR_STS: begin
          nxt_rdat[0] = tmr_sts_ff;
        end
        `CSFT_REG_TMR_EN: begin
          nxt_rdat[0] = tmr_en_ff;
        end
        default: begin
          // clear registers are write-only
          nxt_rdat = 32'h0000_0000;
        end
      endcase
    end
  end

  // [RULE17] error one-shot per channel
  always @* begin
    for (j = 0; j < `CSFT_NCH; j = j + 1) begin
      nxt_shot[j] = ev_w[j*8 + `CSFT_EV_ABN] | ev_w[j*8 + `CSFT_EV_FLT];
    end
  end

  // bus slave: ack one cycle after the request, dropped the next cycle
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= req;
      if (req) begin
        wb_dat_o <= nxt_rdat;
      end
    end
  end

  // software-written configuration
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      // [RULE12] filters start disabled
      for (i = 0; i < `CSFT_NCH; i = i + 1) begin
        flt_ff[i] <= `CSFT_FLT_RST;
      end
      ev_en_ff   <= `CSFT_EV_RST;
      tmr_ivl_ff <= `CSFT_TMR_RST;
      tmr_en_ff  <= 1'b0;
    end else if (ce_i && wr) begin
      if ((adr & `CSFT_GRP_MASK) == `CSFT_REG_FILT_BASE) begin
        // [RULE19] only the addressed channel changes
        flt_ff[cidx] <= (flt_ff[cidx] & ~bmask[`CSFT_FLT_W-1:0]) |
                        (wb_dat_i[`CSFT_FLT_W-1:0] & bmask[`CSFT_FLT_W-1:0]);
      end else if (adr == `CSFT_REG_EV_EN) begin
        ev_en_ff <= (ev_en_ff & ~bmask) | (wb_dat_i & bmask);
      end else if (adr == `CSFT_REG_TMR_IVL) begin
        tmr_ivl_ff <= (tmr_ivl_ff & ~bmask[`CSFT_TMR_W-1:0]) |
                      (wb_dat_i[`CSFT_TMR_W-1:0] & bmask[`CSFT_TMR_W-1:0]);
      end else if (adr == `CSFT_REG_TMR_EN && wb_sel_i[0]) begin
        tmr_en_ff <= wb_dat_i[0];
      end
    end
  end

  // sticky flags; a new event wins over a clear in the same cycle
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ev_sts_ff  <= `CSFT_EV_RST;
      tmr_sts_ff <= 1'b0;
      err_shot_o <= {`CSFT_NCH{1'b0}};
      irq_o      <= 1'b0;
    end else if (ce_i) begin
      // [RULE18] per-bit clear by writing ones
      if (wr && adr == `CSFT_REG_EV_CLR) begin
        ev_sts_ff <= (ev_sts_ff & ~(wb_dat_i & bmask)) | ev_w;
      end else begin
        ev_sts_ff <= ev_sts_ff | ev_w;
      end
      if (wr && adr == `CSFT_REG_TMR_CLR && wb_sel_i[0] && wb_dat_i[0]) begin
        tmr_sts_ff <= tmr_fire;
      end else begin
        tmr_sts_ff <= tmr_sts_ff | tmr_fire;
      end
      err_shot_o <= nxt_shot;
      // [RULE17] level interrupt from enabled flags
      irq_o <= (|(ev_sts_ff & ev_en_ff)) | (tmr_sts_ff & tmr_en_ff);
    end
  end
endmodule

//--- test/csft_top_monitor.sv
// checker for the counter status, filter and timer block; top ports only
// assumes channel 3 stays unfiltered and channel 0 runs a one-step filter
`timescale 1ns/1ps
module csft_top_monitor #(
  parameter MS_CYC = 50000  // cycles per millisecond
) (
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [3:0]  pha_i,
  input wire logic [3:0]  phb_i,
  input wire logic [3:0]  phz_i,
  input wire logic [3:0]  ctl_i,
  input wire logic [3:0]  pha_f_o,
  input wire logic [3:0]  phb_f_o,
  input wire logic [3:0]  phz_f_o,
  input wire logic [3:0]  ctl_f_o,
  input wire logic [3:0]  err_shot_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  // a bus request not yet answered
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence
  // raw phase a of channel 0 held high for eight samples
  sequence s_a0_held;
    pha_i[0] [*8];
  endsequence
  // both filtered phases of channel 3 move on one edge
  sequence s_ab3_both;
    $changed(pha_f_o[3]) && $changed(phb_f_o[3]);
  endsequence

  AST_ACK_LAT:
    assert property (s_take |=> wb_ack_o) else $error("request not answered next cycle");
  AST_ACK_ONE:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  AST_DAT_ZERO:
    assert property (wb_ack_o && !wb_we_i && (wb_adr_i[7:2] >= 6'h0F ||
      wb_adr_i[7:2] == 6'h09 || wb_adr_i[7:2] == 6'h0D) |-> wb_dat_o == 32'h0000_0000)
      else $error("unmapped or clear register read nonzero");
  AST_CH3_PASS:
    assert property (ce_i |=> {pha_f_o[3], phb_f_o[3], phz_f_o[3], ctl_f_o[3]} ==
      $past({pha_i[3], phb_i[3], phz_i[3], ctl_i[3]}))
      else $error("unfiltered channel does not follow its inputs");
  AST_ABN_SHOT:
    assert property (s_ab3_both |-> err_shot_o[3])
      else $error("no error shot after joint phase change");
  AST_HELD_PASS:
    assert property (s_a0_held |-> pha_f_o[0]) else $error("held level not passed");
  AST_SHORT_BLOCK:
    assert property ($rose(pha_f_o[0]) |-> $past(pha_i[0], 2) && $past(pha_i[0], 3))
      else $error("short level reached the counter");
  AST_IRQ_STICKY:
    assert property ($fell(irq_o) |-> $past(wb_stb_i && wb_we_i, 2))
      else $error("interrupt dropped without a write");
endmodule

bind csft_top csft_top_monitor #(.MS_CYC(MS_CYC)) u_mon (
  .ref_clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
  .wb_ack_o, .pha_i, .phb_i, .phz_i, .ctl_i, .pha_f_o, .phb_f_o, .phz_f_o, .ctl_f_o,
  .err_shot_o, .irq_o
);

//--- test/csft_enc_model.sv
// encoder and control line source for the four counter channels
// assumes push-pull lines that change just after a rising clock edge
`timescale 1ns/1ps
module csft_enc_model (
  input  wire logic       ref_clk_i,
  output logic [3:0]      pha_o,
  output logic [3:0]      phb_o,
  output logic [3:0]      phz_o,
  output logic [3:0]      ctl_o
);
  // lines idle low from time zero
  initial begin
    pha_o = 4'h0;
    phb_o = 4'h0;
    phz_o = 4'h0;
    ctl_o = 4'h0;
  end

  // set all four lines of one channel on one edge; a and b together is a fault
  task automatic lvl(input int ch, input logic a, input logic b, input logic z,
                     input logic c);
    @(posedge ref_clk_i);
    pha_o[ch] <= a;
    phb_o[ch] <= b;
    phz_o[ch] <= z;
    ctl_o[ch] <= c;
  endtask

  // chatter on phase a, one toggle per cycle, as noise would
  task automatic buzz(input int ch, input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      pha_o[ch] <= ~pha_o[ch];
    end
  endtask
endmodule

//--- test/csft_top_bench.sv
// bench for the status, filter and timer block: bus tasks and scripted checks
// assumes the encoder model beside it and a 50 MHz reference clock
`timescale 1ns/1ps
module csft_top_bench;
  logic        clk = 1'b0;             // reference clock
  logic        rst_i = 1'b1;           // async reset
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;    // write data
  logic [31:0] rdat;                   // last read data
  logic [3:0]  dir = 4'h0;             // count direction
  logic [3:0]  ev [6] = '{default: 4'h0};  // carry, borrow, four match pulses
  logic [7:0]  e1 = 8'h00;             // expected channel 1 flags
  logic [7:0]  addrs [9] = '{8'h00, 8'h0C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h38, 8'h3C};
  wire  [3:0]  a, b, z, c;             // raw encoder lines
  wire  [3:0]  af, bf, zf, cf;         // filtered levels
  wire  [31:0] rd_o;
  wire         ack, irq;
  int          failures = 0;
  int          checks = 0;

  // short millisecond so the timer fits the run
  csft_top #(.MS_CYC(10)) uut (
    .ref_clk_i(clk), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rd_o),
    .wb_ack_o(ack), .pha_i(a), .phb_i(b), .phz_i(z), .ctl_i(c), .dir_i(dir),
    .carry_i(ev[0]), .borrow_i(ev[1]), .match0_i(ev[2]), .match1_i(ev[3]),
    .match_up_i(ev[4]), .match_dn_i(ev[5]), .pha_f_o(af), .phb_f_o(bf),
    .phz_f_o(zf), .ctl_f_o(cf), .err_shot_o(), .irq_o(irq));
  csft_enc_model enc (.ref_clk_i(clk), .pha_o(a), .phb_o(b), .phz_o(z), .ctl_o(c));

  always #10 clk = ~clk;

  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // classic cycle: hold everything until ack is sampled high
  task wr(input [7:0] ad, input [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= 1'b1;
    adr <= ad;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task rd(input [7:0] ad);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= 1'b0;
    adr <= ad;
    do @(posedge clk); while (ack !== 1'b1);
    rdat = rd_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task chk(input [31:0] seen, input [31:0] exp, input string nm);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one-cycle event pulse on channel 1
  task pulse(input int k);
    @(posedge clk);
    ev[k] <= 4'h2;
    @(posedge clk);
    ev[k] <= 4'h0;
  endtask

  task stop_test;
    if (failures == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // run is a few hundred cycles; this cuts a hung handshake
  initial begin
    tick(4000);
    failures++;
    stop_test;
  end

  initial begin
    tick(5);
    rst_i <= 1'b0;
    foreach (addrs[i]) begin
      rd(addrs[i]);
      chk(rdat, 32'h0000_0000, "reset value");
    end
    dir <= 4'h8;
    enc.lvl(3, 1, 0, 1, 1);
    tick(3);
    rd(8'h1C);
    chk(rdat[4:0], 5'h1D, "ch3 levels");
    wr(8'h00, 32'h0000_0001);
    wr(8'h08, 32'h0000_4000);
    rd(8'h08);
    chk(rdat, 32'h0000_4000, "filter time");
    // chatter faster than the filter must not pass but must be flagged
    enc.buzz(0, 20);
    tick(2);
    chk(af[0], 1'b0, "chatter");
    rd(8'h20);
    chk(rdat[1], 1'b1, "filter error");
    enc.lvl(0, 1, 0, 0, 0);
    tick(3);
    chk(af[0], 1'b0, "early level");
    tick(6);
    chk(af[0], 1'b1, "held level");
    enc.lvl(3, 0, 1, 1, 1);
    tick(3);
    rd(8'h20);
    chk(rdat[24], 1'b1, "abnormal");
    chk(rdat[23:8], 16'h0000, "other channels");
    enc.lvl(3, 0, 0, 0, 0);
    for (int i = 0; i < 6; i++) begin
      pulse(i);
      e1 = e1 | (8'h04 << i);
      rd(8'h20);
      chk(rdat[15:8], e1, "ch1 flags");
    end
    wr(8'h24, 32'h0000_0400);
    rd(8'h20);
    chk(rdat[15:8], 8'hF8, "clear one");
    chk(rdat[24], 1'b1, "ch3 kept");
    wr(8'h28, 32'h0000_0800);
    tick(1);
    chk(irq, 1'b1, "irq set");
    wr(8'h28, 32'h0000_0400);
    tick(1);
    chk(irq, 1'b0, "irq masked");
    pulse(0);
    tick(2);
    chk(irq, 1'b1, "irq carry");
    wr(8'h24, 32'h0000_0400);
    tick(1);
    chk(irq, 1'b0, "irq cleared");
    wr(8'h38, 32'h0000_0001);
    wr(8'h2C, 32'h0000_0002);
    tick(5);
    rd(8'h30);
    chk(rdat, 32'h0000_0000, "timer early");
    tick(20);
    rd(8'h30);
    chk(rdat, 32'h0000_0001, "timer due");
    chk(irq, 1'b1, "timer irq");
    wr(8'h2C, 32'h0000_0000);
    wr(8'h34, 32'h0000_0001);
    rd(8'h30);
    chk(rdat, 32'h0000_0000, "timer cleared");
    // quiet channel 0 before a reset in mid-run
    enc.lvl(0, 0, 0, 0, 0);
    tick(10);
    rst_i <= 1'b1;
    tick(5);
    rst_i <= 1'b0;
    rd(8'h20);
    chk(rdat, 32'h0000_0000, "flags after reset");
    rd(8'h00);
    chk(rdat, 32'h0000_0000, "filter after reset");
    stop_test;
  end
endmodule
